//--- logic/fdc_cmd_phase.sv
// How it works
// - Read-identifier captures first good ID found, reported after three status bytes.
// - Unknown command code is a no-op: standby, single status byte 80H.
// - Dump byte holds sector count after format, final sector after transfers.
// - Drive select bits stay internal; host keeps output register consistent.
// - All transfer commands share parameters and results; low five bits differ.
// - With implied seek enabled, a seek precedes each data transfer automatically.
// - Drive busy flag of addressed drive is set during the seek portion.
// - Failed implied seek reports error status zero and failing cylinder.
// - Sector size code n selects 128 shifted left by n bytes, up to 16K.
`timescale 1ns/1ps
`default_nettype none
module fdc_cmd_phase
    import fdc_cmd_pkg::*;
(
    input  wire logic         core_clk_i,
    input  wire logic         reset_n_i,
    input  wire logic         host_wr_i,
    input  wire logic [7:0]   host_wdata_i,
    input  wire logic         host_rd_i,
    output main_status_t      msr_o,
    output logic [7:0]        res_byte_o,
    output logic              standby_o,
    output logic              implied_seek_o,
    output logic [14:0]       sector_bytes_o,
    output logic              seek_req_o,
    output logic [1:0]        seek_drive_o,
    output logic [7:0]        seek_cyl_o,
    input  wire logic         seek_done_i,
    input  wire logic         seek_fail_i,
    input  wire logic [7:0]   seek_st0_i,
    input  wire logic [7:0]   seek_fail_cyl_i,
    output logic              exec_req_o,
    output exec_req_t         exec_o,
    input  wire logic         exec_done_i,
    input  wire exec_status_t exec_status_i,
    input  wire id_field_t    exec_id_i,
    input  wire dump_cfg_t    dump_cfg_i
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ****************************************************************
    // Decoding
    // ****************************************************************
    function automatic logic is_xfer(input logic [7:0] c);
        logic [4:0] lo;
        lo = c[4:0];
        // Only the low five bits tell the transfer commands apart.
        return (lo == XFER_READ) || (lo == XFER_READ_DEL) ||
               (lo == XFER_WRITE) || (lo == XFER_WRITE_DEL) ||
               (lo == XFER_VERIFY);
    endfunction : is_xfer

    function automatic logic [3:0] param_len(input logic [7:0] c);
        logic [3:0] n;
        n = LEN_INVALID;
        if ((c & MASK_DENSITY) == CMD_READ_ID) begin
            n = LEN_READ_ID;
        end else if ((c & MASK_LOCK) == CMD_LOCK) begin
            n = LEN_ONE;
        end else if (c == CMD_DUMPREG) begin
            n = LEN_ONE;
        end else if (c == CMD_CONFIGURE) begin
            n = LEN_CONFIGURE;
        end else if ((c & MASK_DENSITY) == CMD_FORMAT) begin
            n = LEN_FORMAT;
        end else if (is_xfer(c)) begin
            n = LEN_XFER;
        end
        return n;
    endfunction : param_len

    function automatic logic [14:0] sector_bytes(input logic [7:0] n);
        logic [2:0] code;
        // Codes above the largest size are clamped rather than wrapped.
        code = (n > SECTOR_CODE_MAX) ? SECTOR_CODE_MAX[2:0] : n[2:0];
        return SECTOR_BASE << code;
    endfunction : sector_bytes

    // ****************************************************************
    // Command state
    // ****************************************************************
    phase_t       phase_q, phase_d;
    logic [7:0]   prm_q [0:8];
    logic [7:0]   prm_d [0:8];
    logic [7:0]   res_q [0:9];
    logic [7:0]   res_d [0:9];
    logic [3:0]   cnt_q, cnt_d;
    logic [3:0]   len_q, len_d;
    logic [3:0]   ridx_q, ridx_d;
    logic [3:0]   rlen_q, rlen_d;
    logic         lock_q, lock_d;
    logic [7:0]   feat_q, feat_d;
    logic [7:0]   pre_q, pre_d;
    logic [7:0]   sceot_q, sceot_d;
    logic         stby_q, stby_d;
    logic [14:0]  sec_q, sec_d;
    exec_req_t    exec_q, exec_d;
    main_status_t msr_d;
    logic [7:0]   rbyte_d;

    always_comb begin
        phase_d = phase_q;
        prm_d   = prm_q;
        res_d   = res_q;
        cnt_d   = cnt_q;
        len_d   = len_q;
        ridx_d  = ridx_q;
        rlen_d  = rlen_q;
        lock_d  = lock_q;
        feat_d  = feat_q;
        pre_d   = pre_q;
        sceot_d = sceot_q;
        stby_d  = stby_q;
        sec_d   = sec_q;
        exec_d  = exec_q;
        case (phase_q)
            ST_CMD: begin
                if (host_wr_i) begin
                    prm_d[0] = host_wdata_i;
                    len_d    = param_len(host_wdata_i);
                    cnt_d    = LEN_ONE;
                    stby_d   = 1'b0;
                    if (param_len(host_wdata_i) == LEN_INVALID) begin
                        res_d[0] = INVALID_ST0;
                        rlen_d   = RES_LEN_ONE;
                        ridx_d   = 4'h0;
                        stby_d   = 1'b1;
                        phase_d  = ST_RESULT;
                    end else if (param_len(host_wdata_i) == LEN_ONE) begin
                        phase_d = ST_DISPATCH;
                    end else begin
                        phase_d = ST_PARAM;
                    end
                end
            end
            ST_PARAM: begin
                if (host_wr_i) begin
                    prm_d[cnt_q] = host_wdata_i;
                    cnt_d        = cnt_q + 4'h1;
                    if (cnt_q + 4'h1 == len_q) begin
                        phase_d = ST_DISPATCH;
                    end
                end
            end
            ST_DISPATCH: begin
                ridx_d = 4'h0;
                exec_d.cmd   = prm_q[0];
                exec_d.drive = prm_q[P_DRIVE][1:0];
                exec_d.head  = prm_q[P_DRIVE][HEAD_BIT];
                exec_d.double_density_select = prm_q[0][DENS_BIT];
                exec_d.target = {prm_q[P_CYL], prm_q[P_HEAD],
                                 prm_q[P_REC], prm_q[P_SIZE]};
                exec_d.final_sector_number = prm_q[P_EOT];
                exec_d.gap = prm_q[P_GPL];
                exec_d.dtl = prm_q[P_DTL];
                if ((prm_q[0] & MASK_LOCK) == CMD_LOCK) begin
                    lock_d   = prm_q[0][LOCK_BIT];
                    res_d[0] = {3'h0, prm_q[0][LOCK_BIT], 4'h0};
                    rlen_d   = RES_LEN_ONE;
                    phase_d  = ST_RESULT;
                end else if (prm_q[0] == CMD_DUMPREG) begin
                    for (int i = 0; i < 4; i++) begin
                        res_d[i] = dump_cfg_i.pcn[i];
                    end
                    res_d[4] = dump_cfg_i.srt_hut;
                    res_d[5] = dump_cfg_i.hlt_nd;
                    res_d[6] = sceot_q;
                    res_d[7] = {lock_q, 7'h00};
                    res_d[8] = {1'b0, feat_q[6:0]};
                    res_d[9] = pre_q;
                    rlen_d   = RES_LEN_DUMP;
                    phase_d  = ST_RESULT;
                end else if (prm_q[0] == CMD_CONFIGURE) begin
                    feat_d  = prm_q[CFG_FEAT];
                    pre_d   = prm_q[CFG_PRE];
                    phase_d = ST_CMD;
                end else if ((prm_q[0] & MASK_DENSITY) == CMD_FORMAT) begin
                    sceot_d = prm_q[F_SC];
                    sec_d   = sector_bytes(prm_q[F_SIZE]);
                    exec_d.target.size = prm_q[F_SIZE];
                    phase_d = ST_EXEC;
                end else if (is_xfer(prm_q[0])) begin
                    sceot_d = prm_q[P_EOT];
                    sec_d   = sector_bytes(prm_q[P_SIZE]);
                    phase_d = feat_q[EIS_BIT] ? ST_SEEK : ST_EXEC;
                end else begin
                    phase_d = ST_EXEC;
                end
            end
            ST_SEEK: begin
                if (seek_done_i) begin
                    if (seek_fail_i) begin
                        res_d[0] = seek_st0_i;
                        res_d[1] = BYTE_RST;
                        res_d[2] = BYTE_RST;
                        res_d[3] = seek_fail_cyl_i;
                        res_d[4] = prm_q[P_HEAD];
                        res_d[5] = prm_q[P_REC];
                        res_d[6] = prm_q[P_SIZE];
                        rlen_d   = RES_LEN_XFER;
                        phase_d  = ST_RESULT;
                    end else begin
                        phase_d = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                if (exec_done_i) begin
                    res_d[0] = exec_status_i.st0;
                    res_d[1] = exec_status_i.st1;
                    res_d[2] = exec_status_i.st2;
                    res_d[3] = exec_id_i.cyl;
                    res_d[4] = exec_id_i.head;
                    res_d[5] = exec_id_i.rec;
                    res_d[6] = exec_id_i.size;
                    rlen_d   = RES_LEN_XFER;
                    phase_d  = ST_RESULT;
                end
            end
            ST_RESULT: begin
                if (host_rd_i) begin
                    ridx_d = ridx_q + 4'h1;
                    if (ridx_q + 4'h1 == rlen_q) begin
                        phase_d = ST_CMD;
                    end
                end
            end
            default: begin
                phase_d = ST_CMD;
            end
        endcase
        // Status is registered from next values so it never lags a phase.
        msr_d.rqm      = (phase_d == ST_CMD) || (phase_d == ST_PARAM) ||
                         (phase_d == ST_RESULT);
        msr_d.dio      = (phase_d == ST_RESULT);
        msr_d.cmd_busy = (phase_d != ST_CMD);
        msr_d.drv_busy = 4'h0;
        if (phase_d == ST_SEEK) begin
            msr_d.drv_busy[exec_d.drive] = 1'b1;
        end
        rbyte_d = (phase_d == ST_RESULT) ? res_d[ridx_d] : BYTE_RST;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            phase_q        <= ST_CMD;
            for (int i = 0; i < 9; i++) begin
                prm_q[i] <= BYTE_RST;
            end
            for (int i = 0; i < 10; i++) begin
                res_q[i] <= BYTE_RST;
            end
            cnt_q          <= 4'h0;
            len_q          <= 4'h0;
            ridx_q         <= 4'h0;
            rlen_q         <= 4'h0;
            lock_q         <= 1'b0;
            feat_q         <= FEAT_RST;
            pre_q          <= PRE_RST;
            sceot_q        <= SCEOT_RST;
            stby_q         <= 1'b0;
            sec_q          <= SECTOR_BASE;
            exec_q         <= '0;
            msr_o          <= '{rqm: 1'b1, dio: 1'b0, cmd_busy: 1'b0,
                                drv_busy: 4'h0};
            res_byte_o     <= BYTE_RST;
            seek_req_o     <= 1'b0;
            exec_req_o     <= 1'b0;
        end else begin
            phase_q        <= phase_d;
            prm_q          <= prm_d;
            res_q          <= res_d;
            cnt_q          <= cnt_d;
            len_q          <= len_d;
            ridx_q         <= ridx_d;
            rlen_q         <= rlen_d;
            lock_q         <= lock_d;
            feat_q         <= feat_d;
            pre_q          <= pre_d;
            sceot_q        <= sceot_d;
            stby_q         <= stby_d;
            sec_q          <= sec_d;
            exec_q         <= exec_d;
            msr_o          <= msr_d;
            res_byte_o     <= rbyte_d;
            seek_req_o     <= (phase_d == ST_SEEK);
            exec_req_o     <= (phase_d == ST_EXEC);
        end
    end

    assign standby_o      = stby_q;
    assign implied_seek_o = feat_q[EIS_BIT];
    assign sector_bytes_o = sec_q;
    assign seek_drive_o   = exec_q.drive;
    assign seek_cyl_o     = exec_q.target.cyl;
    assign exec_o         = exec_q;

endmodule : fdc_cmd_phase
`default_nettype wire

//--- logic/fdc_cmd_pkg.sv
`default_nettype none
package fdc_cmd_pkg;

    // ****************************************************************
    // Command codes and masks
    // ****************************************************************
    localparam logic [7:0] CMD_READ_ID    = 8'h0a;
    localparam logic [7:0] MASK_DENSITY   = 8'hbf;
    localparam logic [7:0] CMD_LOCK       = 8'h14;
    localparam logic [7:0] MASK_LOCK      = 8'h7f;
    localparam logic [7:0] CMD_DUMPREG    = 8'h0e;
    localparam logic [7:0] CMD_CONFIGURE  = 8'h13;
    localparam logic [7:0] CMD_FORMAT     = 8'h0d;
    localparam logic [4:0] XFER_READ      = 5'h06;
    localparam logic [4:0] XFER_READ_DEL  = 5'h0c;
    localparam logic [4:0] XFER_WRITE     = 5'h05;
    localparam logic [4:0] XFER_WRITE_DEL = 5'h09;
    localparam logic [4:0] XFER_VERIFY    = 5'h16;

    // ****************************************************************
    // Byte counts, byte positions and bit positions
    // ****************************************************************
    localparam logic [3:0] LEN_INVALID   = 4'h0;
    localparam logic [3:0] LEN_ONE       = 4'h1;
    localparam logic [3:0] LEN_READ_ID   = 4'h2;
    localparam logic [3:0] LEN_CONFIGURE = 4'h4;
    localparam logic [3:0] LEN_FORMAT    = 4'h6;
    localparam logic [3:0] LEN_XFER      = 4'h9;
    localparam logic [3:0] RES_LEN_ONE   = 4'h1;
    localparam logic [3:0] RES_LEN_XFER  = 4'h7;
    localparam logic [3:0] RES_LEN_DUMP  = 4'ha;
    localparam int P_DRIVE   = 1;
    localparam int P_CYL     = 2;
    localparam int P_HEAD    = 3;
    localparam int P_REC     = 4;
    localparam int P_SIZE    = 5;
    localparam int P_EOT     = 6;
    localparam int P_GPL     = 7;
    localparam int P_DTL     = 8;
    localparam int F_SIZE    = 2;
    localparam int F_SC      = 3;
    localparam int CFG_FEAT  = 2;
    localparam int CFG_PRE   = 3;
    localparam int EIS_BIT   = 6;
    localparam int LOCK_BIT  = 7;
    localparam int DENS_BIT  = 6;
    localparam int HEAD_BIT  = 2;
    localparam logic [7:0] INVALID_ST0 = 8'h80;
    localparam logic [14:0] SECTOR_BASE = 15'h0080;
    localparam logic [7:0] SECTOR_CODE_MAX = 8'h07;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] FEAT_RST   = 8'h00;
    localparam logic [7:0] PRE_RST    = 8'h00;
    localparam logic [7:0] SCEOT_RST  = 8'h00;
    localparam logic [7:0] BYTE_RST   = 8'h00;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_CMD, ST_PARAM, ST_DISPATCH, ST_SEEK, ST_EXEC, ST_RESULT
    } phase_t;

    typedef struct packed {
        logic [7:0] cyl;
        logic [7:0] head;
        logic [7:0] rec;
        logic [7:0] size;
    } id_field_t;

    typedef struct packed {
        logic [7:0] st0;
        logic [7:0] st1;
        logic [7:0] st2;
    } exec_status_t;

    typedef struct packed {
        logic       rqm;
        logic       dio;
        logic       cmd_busy;
        logic [3:0] drv_busy;
    } main_status_t;

    typedef struct packed {
        logic [3:0][7:0] pcn;
        logic [7:0]      srt_hut;
        logic [7:0]      hlt_nd;
    } dump_cfg_t;

    typedef struct packed {
        logic [7:0] cmd;
        logic [1:0] drive;
        logic       head;
        logic       double_density_select;
        id_field_t  target;
        logic [7:0] final_sector_number;
        logic [7:0] gap;
        logic [7:0] dtl;
    } exec_req_t;

endpackage : fdc_cmd_pkg
`default_nettype wire

//--- sim/fdc_cmd_phase_props.sv
`timescale 1ns/1ps
`default_nettype none
module fdc_cmd_phase_props
    import fdc_cmd_pkg::*;
(
    input wire logic         core_clk_i,
    input wire logic         reset_n_i,
    input wire logic         host_wr_i,
    input wire logic [7:0]   host_wdata_i,
    input wire logic         host_rd_i,
    input wire main_status_t msr_o,
    input wire logic [7:0]   res_byte_o,
    input wire logic         standby_o,
    input wire logic [14:0]  sector_bytes_o,
    input wire logic         seek_req_o,
    input wire logic [1:0]   seek_drive_o,
    input wire logic         seek_done_i,
    input wire logic         seek_fail_i,
    input wire logic [7:0]   seek_st0_i,
    input wire logic         exec_req_o,
    input wire logic         exec_done_i,
    input wire exec_status_t exec_status_i
);
    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    logic       idle;
    logic [7:0] st0_q;
    assign idle = msr_o.rqm && !msr_o.dio && !msr_o.cmd_busy;
    // A seek end and an execution end never coincide, so one capture serves.
    always_ff @(posedge core_clk_i) begin
        if (seek_done_i || exec_done_i) begin
            st0_q <= seek_done_i ? seek_st0_i : exec_status_i.st0;
        end
    end
    sequence s_lock_in;
        idle && host_wr_i && (host_wdata_i & MASK_LOCK) == CMD_LOCK;
    endsequence
    sequence s_lock_out;
        !msr_o.rqm ##1 (msr_o.dio
            && res_byte_o == {3'h0, $past(host_wdata_i[LOCK_BIT], 2), 4'h0});
    endsequence
    a_lock_result: assert property (s_lock_in |=> s_lock_out)
        else $error("lock result byte wrong");
    a_invalid_code: assert property (
        idle && host_wr_i && host_wdata_i == 8'h00
        |=> msr_o.dio && standby_o && res_byte_o == INVALID_ST0)
        else $error("invalid code result wrong");
    a_invalid_back: assert property (
        msr_o.dio && standby_o && host_rd_i |=> idle && res_byte_o == 8'h00)
        else $error("no return to command phase");
    a_busy_map: assert property (
        msr_o.drv_busy == (seek_req_o ? 4'h1 << seek_drive_o : 4'h0))
        else $error("drive busy flags wrong");
    a_seek_exec: assert property (
        seek_req_o && seek_done_i && !seek_fail_i |=> exec_req_o && !seek_req_o)
        else $error("transfer did not follow seek");
    a_seek_fail: assert property (
        seek_req_o && seek_done_i && seek_fail_i
        |=> !exec_req_o ##[0:1] (msr_o.dio && res_byte_o == st0_q))
        else $error("failed seek status wrong");
    a_exec_hold: assert property (
        exec_req_o && !exec_done_i |=> exec_req_o)
        else $error("execution request dropped early");
    a_exec_result: assert property (
        exec_req_o && exec_done_i
        |=> !exec_req_o && msr_o.dio && res_byte_o == st0_q)
        else $error("first result byte wrong");
    a_sector_size: assert property (
        $onehot(sector_bytes_o) && sector_bytes_o >= SECTOR_BASE)
        else $error("sector size out of range");
endmodule : fdc_cmd_phase_props
bind fdc_cmd_phase fdc_cmd_phase_props i_fdc_cmd_phase_props (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .host_wr_i(host_wr_i),
    .host_wdata_i(host_wdata_i), .host_rd_i(host_rd_i), .msr_o(msr_o),
    .res_byte_o(res_byte_o), .standby_o(standby_o),
    .sector_bytes_o(sector_bytes_o), .seek_req_o(seek_req_o),
    .seek_drive_o(seek_drive_o), .seek_done_i(seek_done_i),
    .seek_fail_i(seek_fail_i), .seek_st0_i(seek_st0_i),
    .exec_req_o(exec_req_o), .exec_done_i(exec_done_i),
    .exec_status_i(exec_status_i)
);
`default_nettype wire

//--- sim/drive_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module drive_engine_model
    import fdc_cmd_pkg::*;
#(
    parameter logic [7:0] FAIL_ST0 = 8'h70
)(
    input  wire logic         core_clk_i,
    input  wire logic         seek_req_i,
    input  wire logic [7:0]   seek_cyl_i,
    input  wire logic         exec_req_i,
    input  wire logic         slow_i,
    input  wire logic         fail_i,
    input  wire exec_status_t status_i,
    input  wire id_field_t    id_i,
    output logic              seek_done_o,
    output logic              seek_fail_o,
    output logic [7:0]        seek_st0_o,
    output logic [7:0]        seek_fail_cyl_o,
    output logic              exec_done_o,
    output exec_status_t      exec_status_o,
    output id_field_t         exec_id_o
);
    // ****************************************************************
    // Seek and execution responder
    // ****************************************************************
    logic [4:0] wait_q  = 5'h00;
    logic       seen_q  = 1'b0;
    logic       kind_q  = 1'b0;
    logic [7:0] noise_q = 8'h5a;
    logic       act;
    logic       done;
    assign act  = seek_req_i || exec_req_i;
    assign done = act && !seen_q && wait_q == (slow_i ? 5'h0c : 5'h01);
    always @(posedge core_clk_i) begin
        noise_q <= noise_q + 8'h3b;
        kind_q  <= seek_req_i;
        if (!act || seek_req_i != kind_q) begin
            wait_q <= 5'h00;
            seen_q <= 1'b0;
        end else if (!seen_q) begin
            wait_q <= wait_q + 5'h01;
            seen_q <= done;
        end
    end
    // Outside a done pulse the answers wander, so stale data never passes.
    assign seek_done_o = done && seek_req_i;
    assign seek_fail_o = done ? fail_i : noise_q[0];
    assign seek_st0_o  = done ? FAIL_ST0 : noise_q;
    assign seek_fail_cyl_o = done ? seek_cyl_i ^ 8'h01 : ~noise_q;
    assign exec_done_o = done && exec_req_i && !seek_req_i;
    assign exec_status_o = done ? status_i : {3{noise_q}};
    assign exec_id_o = done ? id_i : {4{~noise_q}};
endmodule : drive_engine_model
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("unexpected %s expected %0h seen %0h", what, exp, got); \
    end \
end
module tb
    import fdc_cmd_pkg::*;
;
    // ****************************************************************
    // Bench
    // ****************************************************************
    localparam logic [7:0] FAIL_ST0 = 8'h70;
    main_status_t msr_o;
    exec_req_t    exec_o;
    exec_status_t exec_status_i, status;
    id_field_t    exec_id_i, found;
    dump_cfg_t    dump_cfg_i;
    logic [14:0]  sector_bytes_o;
    logic [7:0]   host_wdata_i, res_byte_o, seek_cyl_o, seek_st0_i, fail_cyl;
    logic [1:0]   seek_drive_o;
    logic         core_clk_i, reset_n_i, host_wr_i, host_rd_i, standby_o;
    logic         implied_seek_o, seek_req_o, seek_done_i, seek_fail_i;
    logic         exec_req_o, exec_done_i, slow, fail;
    logic [7:0]   rows [8][3];
    logic [4:0]   xc [5];
    int           comparisons, miscompares;
    // Every other port meets the bench signal of the same name.
    fdc_cmd_phase i_fdc_cmd_phase (.*, .seek_fail_cyl_i(fail_cyl));
    drive_engine_model #(.FAIL_ST0(FAIL_ST0)) i_drive_engine_model (
        .core_clk_i(core_clk_i), .seek_req_i(seek_req_o),
        .seek_cyl_i(seek_cyl_o), .exec_req_i(exec_req_o), .slow_i(slow),
        .fail_i(fail), .status_i(status), .id_i(found),
        .seek_done_o(seek_done_i), .seek_fail_o(seek_fail_i),
        .seek_st0_o(seek_st0_i), .seek_fail_cyl_o(fail_cyl),
        .exec_done_o(exec_done_i), .exec_status_o(exec_status_i),
        .exec_id_o(exec_id_i));
    task automatic final_report;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(posedge core_clk_i);
            host_wr_i    <= 1'b1;
            host_wdata_i <= b[i];
        end
        @(posedge core_clk_i);
        host_wr_i <= 1'b0;
        #1;
    endtask : send
    task automatic wait_on(input logic want_exec);
        int n = 0;
        while ((want_exec ? exec_req_o : msr_o.dio) !== 1'b1) begin
            n++;
            if (n > 200) begin
                miscompares++;
                $display("unexpected wait expected 1 seen 0");
                final_report();
            end
            @(posedge core_clk_i);
            #1;
        end
    endtask : wait_on
    task automatic take(input logic [7:0] exp[$]);
        foreach (exp[i]) begin
            `CHECK("result byte", exp[i], res_byte_o)
            @(posedge core_clk_i);
            host_rd_i <= 1'b1;
            @(posedge core_clk_i);
            host_rd_i <= 1'b0;
            #1;
        end
    endtask : take
    task automatic dump(input logic [7:0] sceot);
        send('{CMD_DUMPREG});
        wait_on(1'b0);
        take('{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'hc4, 8'h1e, sceot, 8'h80, 8'h40,
            8'h05});
    endtask : dump
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    initial begin
        logic [7:0] e[$];
        logic [7:0] c;
        logic [2:0] n;
        comparisons = 0;
        miscompares = 0;
        {reset_n_i, host_wr_i, host_rd_i, host_wdata_i} = '0;
        {slow, fail, status, found} = '0;
        dump_cfg_i = {8'h0d, 8'h0c, 8'h0b, 8'h0a, 8'hc4, 8'h1e};
        xc = '{XFER_READ, XFER_READ_DEL, XFER_WRITE, XFER_WRITE_DEL,
            XFER_VERIFY};
        rows = '{'{8'h00, 8'h80, 8'h01}, '{8'h03, 8'h80, 8'h01},
            '{8'h0f, 8'h80, 8'h01}, '{8'h12, 8'h80, 8'h01},
            '{8'hff, 8'h80, 8'h01}, '{8'h60, 8'h80, 8'h01},
            '{8'h14, 8'h00, 8'h00}, '{8'h94, 8'h10, 8'h00}};
        repeat (19) @(posedge core_clk_i);
        #1;
        `CHECK("status", 7'h40, msr_o)
        `CHECK("sector size", 15'h0080, sector_bytes_o)
        `CHECK("implied seek", 1'b0, implied_seek_o)
        @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1;
        for (int i = 0; i < 8; i++) begin
            send('{rows[i][0]});
            wait_on(1'b0);
            `CHECK("standby", rows[i][2][0], standby_o)
            take('{rows[i][1]});
            `CHECK("phase", 3'h4, {msr_o.rqm, msr_o.dio, msr_o.cmd_busy})
        end
        send('{8'h94});
        send('{8'h00});
        `CHECK("standby", 1'b0, standby_o)
        take('{8'h10});
        send('{CMD_CONFIGURE, 8'h00, 8'h40, 8'h05});
        repeat (3) @(posedge core_clk_i);
        #1;
        `CHECK("implied seek", 1'b1, implied_seek_o)
        status = {8'h06, 8'h00, 8'h00};
        found = {8'h21, 8'h01, 8'h05, 8'h02};
        send('{8'h4a, 8'h06});
        wait_on(1'b1);
        `CHECK("drive", 2'h2, exec_o.drive)
        `CHECK("head", 1'b1, exec_o.head)
        wait_on(1'b0);
        take('{8'h06, 8'h00, 8'h00, 8'h21, 8'h01, 8'h05, 8'h02});
        found = {8'h00, 8'h00, 8'h0a, 8'h07};
        send('{8'h4d, 8'h01, 8'h07, 8'h09, 8'h54, 8'he5});
        wait_on(1'b0);
        take('{8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h07});
        `CHECK("sector size", 15'h4000, sector_bytes_o)
        dump(8'h09);
        for (int i = 0; i < 8; i++) begin
            n = i[2:0];
            c = {n, xc[i % 5]};
            slow = i[0];
            fail = (i == 5);
            status = {8'(i), 8'h20, 8'h40};
            found = {8'h11 + 8'(i), 8'h00, 8'h02, {5'h0, n}};
            send('{c, {5'h0, n}, 8'h10 + 8'(i), {7'h0, n[2]}, 8'h01,
                {5'h0, n}, 8'h12 + 8'(i), 8'h1b, 8'hff});
            e = '{status.st0, status.st1, status.st2, found.cyl, found.head,
                found.rec, found.size};
            if (fail) begin
                e = '{FAIL_ST0, 8'h00, 8'h00, (8'h10 + 8'(i)) ^ 8'h01,
                    {7'h0, n[2]}, 8'h01, {5'h0, n}};
            end else begin
                wait_on(1'b1);
                `CHECK("command", c, exec_o.cmd)
                `CHECK("size code", {5'h0, n}, exec_o.target.size)
                `CHECK("final sector", 8'h12 + 8'(i), exec_o.final_sector_number)
            end
            wait_on(1'b0);
            take(e);
            if (!fail) begin
                `CHECK("sector size", SECTOR_BASE << n, sector_bytes_o)
            end
        end
        dump(8'h19);
        final_report();
    end
endmodule : tb
`default_nettype wire
